/* File: hdl/cpu_fifo_port_pkg.sv */
// Shared constants and types for the CPU FIFO and bit-bang port.
package cpu_fifo_port_pkg;

  localparam int PIN_W = 8;

  // Register select values on the single address bit.
  localparam logic REG_DATA_PIPE = 1'b0;
  localparam logic REG_PORT_STATUS = 1'b1;

  // Status byte field positions; the upper nibble reads as zero.
  localparam int ST_RX_DATA_AVAILABLE = 0;
  localparam int ST_TX_SPACE_AVAILABLE = 1;
  localparam int ST_SUSPEND = 2;
  localparam int ST_CONFIGURED = 3;

  // Bit-mode command values.
  localparam logic [7:0] BITMODE_RESET = 8'h00;
  localparam logic [7:0] BITMODE_ASYNC = 8'h01;
  localparam logic [7:0] BITMODE_SYNC = 8'h04;

  // Reset values.
  localparam logic [PIN_W-1:0] PIN_OUT_RESET = 8'h00;
  localparam logic [PIN_W-1:0] DIR_RESET = 8'h00;
  localparam logic [3:0] CTL_IDLE = 4'hf;

  typedef enum logic [2:0]
  {
    MODE_BASE = 3'b001,
    MODE_ASYNC_BB = 3'b010,
    MODE_SYNC_BB = 3'b100
  } mode_e;

  // One state per step of a synchronous bit-bang byte.
  typedef enum logic [6:0]
  {
    SEQ_IDLE = 7'b0000001,
    SEQ_READ = 7'b0000010,
    SEQ_SEND = 7'b0000100,
    SEQ_CHANGE = 7'b0001000,
    SEQ_SETUP = 7'b0010000,
    SEQ_UPDATE = 7'b0100000,
    SEQ_UPDATE_END = 7'b1000000
  } seq_state_e;

endpackage

/* File: hdl/pin_filter.sv */
// Three-stage input synchroniser with second/third stage agreement filter.
`timescale 1ns/100ps
module pin_filter
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Asynchronous pins in, filtered level out
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;
  logic [W-1:0] level_d;

  // A bit moves only once the two settled stages agree on it.
  always_comb
  begin
    level_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_q);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule

/* File: hdl/sync_bb_seq.sv */
// Step sequencer for one synchronous bit-bang byte.
`timescale 1ns/100ps
module sync_bb_seq
  import cpu_fifo_port_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Conditions
  input wire logic enable,
  input wire logic rx_valid,
  input wire logic tx_ready,
  // Step requests, decoded from the current state
  output logic pop_req,
  output logic capture_req,
  output logic push_req,
  output logic load_req,
  output logic sample_high,
  output logic update_low
);

  seq_state_e state_q;
  seq_state_e state_d;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE:
      begin
        // A byte is taken only when its sample has room upstream.
        if (enable && rx_valid && tx_ready)
          state_d = SEQ_READ;
      end
      SEQ_READ: state_d = SEQ_SEND;
      SEQ_SEND: state_d = SEQ_CHANGE;
      SEQ_CHANGE: state_d = SEQ_SETUP;
      SEQ_SETUP: state_d = SEQ_UPDATE;
      SEQ_UPDATE: state_d = SEQ_UPDATE_END;
      SEQ_UPDATE_END: state_d = SEQ_IDLE;
      default: state_d = SEQ_IDLE;
    endcase
    if (!enable)
      state_d = SEQ_IDLE;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= SEQ_IDLE;
    else
      state_q <= state_d;
  end

  // Pins are read before the new byte is applied.
  assign capture_req = (state_q == SEQ_READ);
  assign pop_req = (state_q == SEQ_READ);
  assign push_req = (state_q == SEQ_SEND);
  assign sample_high = (state_q == SEQ_SEND);
  assign load_req = (state_q == SEQ_CHANGE);
  assign update_low = (state_q == SEQ_UPDATE);

endmodule

/* File: hdl/cpu_fifo_and_bitbang_port.sv */
// Parallel port of one bridge channel: CPU-style FIFO and bit-bang modes.
`timescale 1ns/100ps
module cpu_fifo_and_bitbang_port
  import cpu_fifo_port_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Configuration strap, taken once after reset
  input wire logic cpu_fifo_strap,
  // Processor bus pins
  input wire logic cs_n,
  input wire logic register_select_bit,
  input wire logic rd_n,
  input wire logic wr_n,
  // Shared data and bit-bang pins
  input wire logic [cpu_fifo_port_pkg::PIN_W-1:0] pin_in,
  output logic [cpu_fifo_port_pkg::PIN_W-1:0] pin_out,
  output logic [cpu_fifo_port_pkg::PIN_W-1:0] pin_oe,
  // Bit-bang strobes
  output logic pin_sample_strobe_n,
  output logic pin_update_strobe_n,
  // Receive FIFO (host to pins)
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Transmit FIFO (pins to host)
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic send_immediate,
  // Bus state and commands from the USB side
  input wire logic usb_suspend,
  input wire logic usb_configured,
  input wire logic bitmode_valid,
  input wire logic [7:0] bitmode_value,
  input wire logic [cpu_fifo_port_pkg::PIN_W-1:0] bitmode_dir_mask,
  input wire logic baud_tick
);

  import cpu_fifo_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0] ctl_f;
  logic [PIN_W-1:0] pin_f;
  logic cs_f;
  logic a0_f;
  logic rd_f;
  logic wr_f;

  pin_filter #(.W(4), .INIT(CTL_IDLE)) u_ctl_filter
  (
    .clock(clock),
    .reset_n(reset_n),
    .raw({cs_n, register_select_bit, rd_n, wr_n}),
    .level(ctl_f)
  );

  pin_filter #(.W(PIN_W), .INIT(PIN_OUT_RESET)) u_pin_filter
  (
    .clock(clock),
    .reset_n(reset_n),
    .raw(pin_in),
    .level(pin_f)
  );

  assign cs_f = ctl_f[3];
  assign a0_f = ctl_f[2];
  assign rd_f = ctl_f[1];
  assign wr_f = ctl_f[0];

  ////////////////////////////////////////////////////////////////////////////
  // Mode and direction state

  mode_e mode_q;
  mode_e mode_d;
  logic cfg_done_q;
  logic cfg_done_d;
  logic cpu_mode_q;
  logic cpu_mode_d;
  logic [PIN_W-1:0] dir_q;
  logic [PIN_W-1:0] dir_d;

  always_comb
  begin
    mode_d = mode_q;
    dir_d = dir_q;
    cfg_done_d = 1'b1;
    cpu_mode_d = cpu_mode_q;
    // The strap is caught once, on the first edge after reset release.
    if (!cfg_done_q)
      cpu_mode_d = cpu_fifo_strap;
    if (bitmode_valid)
    begin
      dir_d = bitmode_dir_mask;
      case (bitmode_value)
        BITMODE_ASYNC: mode_d = MODE_ASYNC_BB;
        BITMODE_SYNC: mode_d = MODE_SYNC_BB;
        BITMODE_RESET: mode_d = MODE_BASE;
        default: mode_d = mode_q;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q <= MODE_BASE;
      cfg_done_q <= 1'b0;
      cpu_mode_q <= 1'b0;
      dir_q <= DIR_RESET;
    end
    else
    begin
      mode_q <= mode_d;
      cfg_done_q <= cfg_done_d;
      cpu_mode_q <= cpu_mode_d;
      dir_q <= dir_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous bit-bang sequencer

  logic sbb_en;
  logic abb_en;
  logic cpu_en;
  logic seq_pop;
  logic seq_capture;
  logic seq_push;
  logic seq_load;
  logic seq_sample_high;
  logic seq_update_low;

  assign sbb_en = (mode_q == MODE_SYNC_BB);
  assign abb_en = (mode_q == MODE_ASYNC_BB);
  assign cpu_en = (mode_q == MODE_BASE) && cpu_mode_q;

  sync_bb_seq u_seq
  (
    .clock(clock),
    .reset_n(reset_n),
    .enable(sbb_en),
    .rx_valid(rx_valid),
    .tx_ready(tx_ready),
    .pop_req(seq_pop),
    .capture_req(seq_capture),
    .push_req(seq_push),
    .load_req(seq_load),
    .sample_high(seq_sample_high),
    .update_low(seq_update_low)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data path and strobes

  logic rd_prev_q;
  logic wr_prev_q;
  logic rd_fall;
  logic rd_end;
  logic wr_rise;
  logic rx_take;
  logic [7:0] status_v;
  logic cpu_rd_act_q;
  logic cpu_rd_act_d;
  logic [7:0] cpu_dout_q;
  logic [7:0] cpu_dout_d;
  logic [PIN_W-1:0] bb_out_q;
  logic [PIN_W-1:0] bb_out_d;
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  logic [PIN_W-1:0] sample_q;
  logic [PIN_W-1:0] sample_d;
  logic rx_ready_q;
  logic rx_ready_d;
  logic tx_valid_q;
  logic tx_valid_d;
  logic [7:0] tx_data_q;
  logic [7:0] tx_data_d;
  logic send_imm_q;
  logic send_imm_d;
  logic sample_n_q;
  logic sample_n_d;
  logic update_n_q;
  logic update_n_d;
  logic [PIN_W-1:0] pin_out_q;
  logic [PIN_W-1:0] pin_out_d;
  logic [PIN_W-1:0] pin_oe_q;
  logic [PIN_W-1:0] pin_oe_d;

  // Decoding waits for the filtered strobe edge, so select and address
  // have settled by then.
  assign rd_fall = cpu_en && !cs_f && rd_prev_q && !rd_f;
  assign rd_end = rd_f || cs_f;
  assign wr_rise = cpu_en && !cs_f && !wr_prev_q && wr_f;
  assign rx_take = rx_ready_q && rx_valid;

  always_comb
  begin
    status_v = 8'h00;
    status_v[ST_RX_DATA_AVAILABLE] = rx_valid;
    status_v[ST_TX_SPACE_AVAILABLE] = tx_ready;
    status_v[ST_SUSPEND] = usb_suspend;
    status_v[ST_CONFIGURED] = usb_configured;
  end

  always_comb
  begin
    cpu_rd_act_d = cpu_rd_act_q && !rd_end;
    cpu_dout_d = cpu_dout_q;
    bb_out_d = bb_out_q;
    hold_d = hold_q;
    sample_d = sample_q;
    rx_ready_d = 1'b0;
    tx_valid_d = 1'b0;
    tx_data_d = tx_data_q;
    send_imm_d = 1'b0;
    sample_n_d = 1'b1;
    update_n_d = 1'b1;
    if (cpu_en)
    begin
      if (rd_fall)
      begin
        cpu_rd_act_d = 1'b1;
        if (a0_f == REG_PORT_STATUS)
          cpu_dout_d = status_v;
        else
        begin
          // An empty pipe reads as zero and pops nothing.
          cpu_dout_d = 8'h00;
          rx_ready_d = rx_valid;
        end
      end
      if (rx_take)
        cpu_dout_d = rx_data;
      if (wr_rise && a0_f == REG_DATA_PIPE && tx_ready)
      begin
        tx_valid_d = 1'b1;
        tx_data_d = pin_f;
      end
      if (wr_rise && a0_f == REG_PORT_STATUS)
        send_imm_d = 1'b1;
    end
    else if (abb_en)
    begin
      // Each tick samples the pins and, with new data waiting, fetches it.
      if (baud_tick && rx_valid && !rx_ready_q)
        rx_ready_d = 1'b1;
      if (rx_take)
      begin
        bb_out_d = rx_data;
        update_n_d = 1'b0;
      end
      if (baud_tick)
      begin
        sample_n_d = 1'b0;
        if (tx_ready)
        begin
          tx_valid_d = 1'b1;
          tx_data_d = pin_f;
        end
      end
    end
    else if (sbb_en)
    begin
      rx_ready_d = seq_pop;
      if (rx_take)
        hold_d = rx_data;
      if (seq_capture)
        sample_d = pin_f;
      if (seq_push)
      begin
        tx_valid_d = 1'b1;
        tx_data_d = sample_q;
      end
      if (seq_load)
        bb_out_d = hold_q;
      // The sample strobe rests low here and rises once per byte.
      sample_n_d = seq_sample_high;
      update_n_d = !seq_update_low;
    end
  end

  // Each pin picks its own direction; CPU reads drive the whole byte.
  for (genvar g = 0; g < PIN_W; g++)
  begin : g_pin
    assign pin_out_d[g] = cpu_en ? cpu_dout_q[g] :
                          (abb_en || sbb_en) ? bb_out_q[g] : 1'b0;
    assign pin_oe_d[g] = cpu_en ? cpu_rd_act_q :
                         (abb_en || sbb_en) ? dir_q[g] : 1'b0;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      cpu_rd_act_q <= 1'b0;
      cpu_dout_q <= 8'h00;
      bb_out_q <= PIN_OUT_RESET;
      hold_q <= 8'h00;
      sample_q <= PIN_OUT_RESET;
      rx_ready_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      send_imm_q <= 1'b0;
      sample_n_q <= 1'b1;
      update_n_q <= 1'b1;
      pin_out_q <= PIN_OUT_RESET;
      pin_oe_q <= DIR_RESET;
    end
    else
    begin
      rd_prev_q <= rd_f;
      wr_prev_q <= wr_f;
      cpu_rd_act_q <= cpu_rd_act_d;
      cpu_dout_q <= cpu_dout_d;
      bb_out_q <= bb_out_d;
      hold_q <= hold_d;
      sample_q <= sample_d;
      rx_ready_q <= rx_ready_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      send_imm_q <= send_imm_d;
      sample_n_q <= sample_n_d;
      update_n_q <= update_n_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign pin_sample_strobe_n = sample_n_q;
  assign pin_update_strobe_n = update_n_q;
  assign rx_ready = rx_ready_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign send_immediate = send_imm_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_sample_edge;
    $rose(pin_sample_strobe_n) ##1 $fell(pin_sample_strobe_n);
  endsequence

  sequence s_update_pulse;
    $fell(pin_update_strobe_n) ##1 $rose(pin_update_strobe_n);
  endsequence

  a_deselect_ignored: assert property (
    (cs_f && !rd_f && rd_prev_q) |=> !rx_ready_q)
    else $error("access with select high was taken");

  a_status_layout: assert property (
    (rd_fall && a0_f) |=>
      cpu_dout_q == {4'h0, $past(usb_configured), $past(usb_suspend),
                     $past(tx_ready), $past(rx_valid)})
    else $error("status byte layout wrong");

  a_strap_fixed: assert property (
    cfg_done_q |=> $stable(cpu_mode_q))
    else $error("cpu mode changed after reset");

  a_async_hold: assert property (
    (abb_en && $past(abb_en) && !$past(rx_take)) |-> $stable(bb_out_q))
    else $error("async output moved without new data");

  a_async_pace: assert property (
    (abb_en && $rose(rx_ready_q)) |-> $past(baud_tick))
    else $error("async fetch without baud tick");

  a_sync_room: assert property (
    (sbb_en && $past(sbb_en, 2) && rx_ready_q) |-> $past(tx_ready, 2))
    else $error("sync byte taken without transmit room");

  a_sync_steps: assert property (
    (sbb_en && $rose(pin_sample_strobe_n)) |->
      s_sample_edge ##2 s_update_pulse)
    else $error("sync bit-bang step order wrong");

  a_sample_push: assert property (
    (sbb_en && $rose(pin_sample_strobe_n)) |-> tx_valid_q)
    else $error("sample strobe rose without push");

  a_dir_hold: assert property (
    !$stable(dir_q) |-> $past(bitmode_valid))
    else $error("direction changed without setup command");

  a_mode_async: assert property (
    (bitmode_valid && bitmode_value == BITMODE_ASYNC) |=> abb_en)
    else $error("value 1 did not select async bit-bang");

  a_mode_sync: assert property (
    (bitmode_valid && bitmode_value == BITMODE_SYNC) |=> sbb_en)
    else $error("value 4 did not select sync bit-bang");

  a_flush_req: assert property (
    (wr_rise && a0_f) |=> send_immediate ##1 !send_immediate)
    else $error("send-immediate pulse missing");

endmodule

/* File: tb/cpu_bus_model.sv */
// External processor and pin-side logic model for the parallel port.
`timescale 1ns/100ps
module cpu_bus_model
(
  // Clock
  input wire logic clock,
  // Processor bus pins
  output logic cs_n,
  output logic register_select_bit,
  output logic rd_n,
  output logic wr_n,
  // Shared pins
  input wire logic [cpu_fifo_port_pkg::PIN_W-1:0] pin_out,
  input wire logic [cpu_fifo_port_pkg::PIN_W-1:0] pin_oe,
  output logic [cpu_fifo_port_pkg::PIN_W-1:0] pin_in
);
  import cpu_fifo_port_pkg::*;
  logic [PIN_W-1:0] ext_val;
  logic [PIN_W-1:0] ext_oe;
  logic [PIN_W-1:0] float_q;
  initial
  begin
    cs_n = 1'b1;
    register_select_bit = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ext_val = 8'h00;
    ext_oe = 8'h00;
    float_q = 8'h5a;
  end
  // Lines nobody drives must not look like a stable value, so they toggle.
  always @(posedge clock)
    float_q <= ~float_q;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                | (~pin_oe & ~ext_oe & float_q);
  task automatic drive_pins(input logic [7:0] oe, input logic [7:0] val);
    @(posedge clock);
    #1;
    ext_oe = oe;
    ext_val = val;
  endtask
  // One strobe per access, each edge held long enough for the input filter.
  task automatic access(input logic sel, input logic addr, input logic wr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge clock);
    #1;
    cs_n = sel;
    register_select_bit = addr;
    ext_val = wdata;
    ext_oe = {8{wr}};
    repeat (2) @(posedge clock);
    #1;
    if (wr)
      wr_n = 1'b0;
    else
      rd_n = 1'b0;
    repeat (10) @(posedge clock);
    rdata = pin_in;
    #1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    cs_n = 1'b1;
    ext_oe = 8'h00;
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking testbench for the CPU FIFO and bit-bang port.
`timescale 1ns/100ps
module tb;
  import cpu_fifo_port_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b0;
  logic cs_n, register_select_bit, rd_n, wr_n;
  logic [7:0] pin_in, pin_out, pin_oe, rx_data, tx_data;
  logic [7:0] bitmode_value = 8'h00;
  logic [7:0] bitmode_dir_mask = 8'h00;
  logic sstb_n, ustb_n, rx_ready, tx_valid, send_immediate;
  logic rx_valid = 1'b0;
  logic tx_ready = 1'b1;
  logic usb_suspend = 1'b0;
  logic usb_configured = 1'b0;
  logic bitmode_valid = 1'b0;
  logic baud_tick = 1'b0;
  logic ustb_q = 1'b1;
  logic sstb_q = 1'b1;
  logic [7:0] oe_seen, rd;
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  int pops, flushes, ufalls, srises;
  int err_count = 0;
  int compares = 0;
  always #2 clock = ~clock;
  cpu_fifo_and_bitbang_port i_cpu_fifo_and_bitbang_port (.clock(clock),
    .reset_n(reset_n), .cpu_fifo_strap(strap), .cs_n(cs_n),
    .register_select_bit(register_select_bit), .rd_n(rd_n), .wr_n(wr_n),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_sample_strobe_n(sstb_n), .pin_update_strobe_n(ustb_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .send_immediate(send_immediate), .usb_suspend(usb_suspend),
    .usb_configured(usb_configured), .bitmode_valid(bitmode_valid),
    .bitmode_value(bitmode_value), .bitmode_dir_mask(bitmode_dir_mask),
    .baud_tick(baud_tick));
  cpu_bus_model i_cpu_bus_model (.clock(clock), .cs_n(cs_n),
    .register_select_bit(register_select_bit), .rd_n(rd_n), .wr_n(wr_n),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  // The bench plays both USB FIFOs and counts strobe edges.
  always @(posedge clock)
  begin
    if (rx_ready === 1'b1 && rx_valid)
    begin
      pops++;
      void'(rx_q.pop_front());
    end
    if (tx_valid === 1'b1)
      tx_q.push_back(tx_data);
    if (send_immediate === 1'b1)
      flushes++;
    if (ustb_q && ustb_n === 1'b0)
      ufalls++;
    if (!sstb_q && sstb_n === 1'b1)
      srises++;
    ustb_q = ustb_n;
    sstb_q = sstb_n;
    oe_seen = oe_seen | pin_oe;
    #1;
    rx_valid = rx_q.size() != 0;
    rx_data = rx_valid ? rx_q[0] : 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    reset_n = 1'b0;
    strap = s;
    repeat (16) @(posedge clock);
    #1;
    reset_n = 1'b1;
    rx_q.delete();
    tx_q.delete();
    {pops, flushes, ufalls, srises} = '0;
    oe_seen = 8'h00;
    repeat (8) @(posedge clock);
  endtask
  task automatic cmd(input logic [7:0] v, input logic [7:0] m);
    @(posedge clock);
    #1;
    bitmode_valid = 1'b1;
    bitmode_value = v;
    bitmode_dir_mask = m;
    @(posedge clock);
    #1;
    bitmode_valid = 1'b0;
    repeat (4) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_no_strap();
    do_reset(1'b0);
    rx_q.push_back(8'h11);
    i_cpu_bus_model.access(1'b0, REG_PORT_STATUS, 1'b0, 8'h00, rd);
    i_cpu_bus_model.access(1'b0, REG_DATA_PIPE, 1'b0, 8'h00, rd);
    check("oe without strap", oe_seen, 8'h00);
    check("pops without strap", 8'(pops), 8'h00);
    $display("test no_strap done");
  endtask
  task automatic t_read();
    logic [3:0] pat[4] = '{4'h5, 4'ha, 4'hf, 4'h0};
    do_reset(1'b1);
    foreach (pat[i])
    begin
      rx_q.delete();
      if (pat[i][0])
        rx_q.push_back(8'h77);
      usb_configured = pat[i][3];
      usb_suspend = pat[i][2];
      tx_ready = pat[i][1];
      // Only the low nibble is defined; the rest is ignored here.
      i_cpu_bus_model.access(1'b0, REG_PORT_STATUS, 1'b0, 8'h00, rd);
      check("status", {4'h0, rd[3:0]}, {4'h0, pat[i]});
    end
    i_cpu_bus_model.access(1'b0, REG_DATA_PIPE, 1'b0, 8'h00, rd);
    check("empty pipe", rd, 8'h00);
    rx_q.push_back(8'h5a);
    i_cpu_bus_model.access(1'b1, REG_DATA_PIPE, 1'b0, 8'h00, rd);
    check("pops deselected", 8'(pops), 8'h00);
    i_cpu_bus_model.access(1'b0, REG_PORT_STATUS, 1'b0, 8'h00, rd);
    i_cpu_bus_model.access(1'b0, REG_DATA_PIPE, 1'b0, 8'h00, rd);
    check("pipe read", rd, 8'h5a);
    check("pipe pops", 8'(pops), 8'h01);
    $display("test read done");
  endtask
  task automatic t_write();
    tx_ready = 1'b1;
    i_cpu_bus_model.access(1'b0, REG_DATA_PIPE, 1'b1, 8'ha5, rd);
    i_cpu_bus_model.access(1'b1, REG_DATA_PIPE, 1'b1, 8'h3c, rd);
    i_cpu_bus_model.access(1'b0, REG_PORT_STATUS, 1'b1, 8'hc3, rd);
    check("pushes", 8'(tx_q.size()), 8'h01);
    check("pushed byte", tx_q[0], 8'ha5);
    check("flushes", 8'(flushes), 8'h01);
    $display("test write done");
  endtask
  task automatic t_async();
    do_reset(1'b0);
    cmd(BITMODE_ASYNC, 8'h0f);
    i_cpu_bus_model.drive_pins(8'hf0, 8'ha0);
    rx_q.push_back(8'h3c);
    repeat (20) @(posedge clock);
    check("async oe", pin_oe, 8'h0f);
    check("async hold", pin_out & 8'h0f, PIN_OUT_RESET & 8'h0f);
    for (int k = 0; k < 2; k++)
    begin
      #1;
      baud_tick = 1'b1;
      @(posedge clock);
      #1;
      baud_tick = 1'b0;
      repeat (8) @(posedge clock);
      check("async out", pin_out & 8'h0f, 8'h0c);
      // Output pins read back what they drive, so the second sample
      // carries the low nibble written by the first tick.
      check("async sample", tx_q[k], k ? 8'hac : 8'ha0);
    end
    check("async pops", 8'(pops), 8'h01);
    check("update falls", 8'(ufalls), 8'h01);
    check("sample rises", 8'(srises), 8'h02);
    $display("test async done");
  endtask
  task automatic t_sync();
    logic [7:0] seq[3] = '{8'hff, 8'h55, 8'haa};
    cmd(BITMODE_SYNC, 8'hff);
    i_cpu_bus_model.drive_pins(8'h00, 8'h00);
    tx_q.delete();
    {pops, ufalls, srises} = '0;
    foreach (seq[i])
    begin
      rx_q.push_back(seq[i]);
      repeat (14) @(posedge clock);
    end
    check("sync out", pin_out, 8'haa);
    check("sync lag 1", tx_q[1], 8'hff);
    check("sync lag 2", tx_q[2], 8'h55);
    check("update pulses", 8'(ufalls), 8'h03);
    check("sample rises", 8'(srises), 8'h03);
    #1;
    tx_ready = 1'b0;
    rx_q.push_back(8'h0f);
    repeat (20) @(posedge clock);
    check("stalled pops", 8'(pops), 8'h03);
    #1;
    tx_ready = 1'b1;
    repeat (14) @(posedge clock);
    check("resumed pops", 8'(pops), 8'h04);
    cmd(BITMODE_SYNC, 8'h00);
    i_cpu_bus_model.drive_pins(8'hff, 8'h96);
    repeat (8) @(posedge clock);
    // With every pin an input, a byte is still sent to get a sample.
    rx_q.push_back(8'h00);
    repeat (14) @(posedge clock);
    check("inputs oe", pin_oe, 8'h00);
    check("inputs sample", tx_q[tx_q.size()-1], 8'h96);
    // Back to base mode: a full mask must not drive pins without the strap.
    cmd(BITMODE_RESET, 8'hff);
    check("base oe", pin_oe, 8'h00);
    check("base sample strobe", {7'h00, sstb_n}, 8'h01);
    $display("test sync done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    t_no_strap();
    t_read();
    t_write();
    t_async();
    t_sync();
    tally_and_finish();
  end
endmodule
